// File: core/ldr_pkg.sv
/*
 * Shared constants and carrier types of the status and nonvolatile-store register slice.
 * Assumes a byte-wide register access port driven by the serial control port front end.
 */
package ldr_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_STRING_FAULT  = 8'h10;
   localparam logic [7:0] ADDR_FAULT_WIPE    = 8'h11;
   localparam logic [7:0] ADDR_SILICON_REV   = 8'h12;
   localparam logic [7:0] ADDR_HEAT_UPPER    = 8'h13;
   localparam logic [7:0] ADDR_HEAT_LOWER    = 8'h14;
   localparam logic [7:0] ADDR_DRIVE_UPPER   = 8'h15;
   localparam logic [7:0] ADDR_DRIVE_LOWER   = 8'h16;
   localparam logic [7:0] ADDR_DUTY_UPPER    = 8'h17;
   localparam logic [7:0] ADDR_DUTY_LOWER    = 8'h18;
   localparam logic [7:0] ADDR_NVM_CONTROL   = 8'h19;
   localparam logic [7:0] ADDR_NVM_KEY       = 8'h1A;
   localparam logic [7:0] ADDR_SHADOW_FIRST  = 8'h60;
   localparam logic [7:0] ADDR_SHADOW_LAST   = 8'h78;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int         OPEN_BIT           = 5;
   localparam int         SHORT_BIT          = 4;
   localparam int         WIPE_BIT           = 0;
   localparam int         IDLE_BIT           = 7;
   localparam int         BURN_BIT           = 1;
   localparam int         RESTORE_BIT        = 0;
   localparam logic [7:0] RST_STRING_FAULT   = 8'h00;
   localparam logic [7:0] RST_NVM_CONTROL    = 8'h80;
   localparam logic [15:0] RST_DUTY          = 16'h0000;
   localparam logic [7:0] KEY_FIRST          = 8'h08;
   localparam logic [7:0] KEY_SECOND         = 8'hBA;
   localparam logic [7:0] KEY_THIRD          = 8'hEF;
   localparam int         SHADOW_DEPTH       = 25;
   localparam int         SHADOW_AW          = 5;

   // ----------------------------------------------------------------
   // store operation times
   // ----------------------------------------------------------------
   localparam int         CLK_MHZ            = 250;
   localparam int         BURN_TIME_MS       = 200;
   localparam int         RESTORE_TIME_MS    = 1;
   localparam int         BURN_CYCLES        = BURN_TIME_MS * CLK_MHZ * 1000;
   localparam int         RESTORE_CYCLES     = RESTORE_TIME_MS * CLK_MHZ * 1000;

   // ----------------------------------------------------------------
   // unlock sequence states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      KEY_LOCKED = 4'h1,
      KEY_GOT1   = 4'h2,
      KEY_GOT2   = 4'h4,
      KEY_OPEN   = 4'h8
   } ldr_key_state_t;

   // analog side fault report
   typedef struct packed {
      logic       open_string;
      logic       shorted_string;
      logic [3:0] faulty_string;
   } ldr_fault_t;

   // live measurement values
   typedef struct packed {
      logic [10:0] die_heat;
      logic [11:0] string_drive_level;
      logic [15:0] duty;
   } ldr_meas_t;
endpackage : ldr_pkg

// File: core/ldr_shadow_mem.sv
/*
 * Small byte memory holding the configuration shadow registers.
 * Assumes one write or one read per cycle from the register slice; read data are registered.
 */
module ldr_shadow_mem #(
   parameter int DEPTH = ldr_pkg::SHADOW_DEPTH,
   parameter int AW    = ldr_pkg::SHADOW_AW
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata
);
   logic [7:0] cells [DEPTH];

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   // write port and registered read
   always_ff @(posedge clk) begin
      if (we) begin
         cells[addr] <= wdata;
      end
      rdata <= cells[addr];
   end
endmodule : ldr_shadow_mem

// File: core/ldr_regs.sv
/*
 * Status readback and nonvolatile-store control register slice of an LED backlight driver.
 * Assumes a serial port front end issuing single-cycle byte read and write strobes on clk,
 * fault and measurement inputs from asynchronous analog logic, and an external store macro
 * that copies shadow contents to and from nonvolatile cells while nvm_burn or nvm_restore is up.
 */
// Function
// - bit 5 reports open string fault
// - bit 4 reports shorted string fault
// - bits 3:0 one-hot name faulty string
// - writing wipe bit 0 clears faults
// - revision: base layer 7:4, mask step 3:0
// - temperature 11 bits split upper/lower
// - upper temperature read latches whole value
// - drive level 12 bits split upper/lower
// - upper drive read latches drive and duty
// - duty 16 bits split, resets zero
// - control bit 7 low while busy
// - control bit 1 starts store burn
// - control bit 0 restores shadow defaults
// - key bytes 08 BA EF unlock store
// - any other key byte locks again
module ldr_regs #(
   parameter logic [3:0] BASE_LAYER_REV = 4'h1,   // arbitrary value
   parameter logic [3:0] MASK_REV_STEP  = 4'h0,   // arbitrary value
   parameter int         BURN_CYCLES    = ldr_pkg::BURN_CYCLES,
   parameter int         RESTORE_CYCLES = ldr_pkg::RESTORE_CYCLES
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   input  wire logic [7:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   output logic      [7:0]         reg_rdata,
   output logic                    reg_rvalid,
   input  wire ldr_pkg::ldr_fault_t fault_in,
   input  wire ldr_pkg::ldr_meas_t  meas_in,
   input  wire logic               nvm_done,
   output logic                    nvm_burn,
   output logic                    nvm_restore,
   output logic                    nvm_unlocked
);
   localparam int SW = $bits(ldr_pkg::ldr_fault_t);
   localparam int MW = $bits(ldr_pkg::ldr_meas_t);
   // store timer wide enough for the longer operation
   localparam int LONG_OP = (BURN_CYCLES > RESTORE_CYCLES) ? BURN_CYCLES : RESTORE_CYCLES;
   localparam int OPW     = $clog2(LONG_OP + 1);

   logic [SW-1:0]           fault_s1;
   logic [SW-1:0]           fault_s2;
   logic [MW-1:0]           meas_s1;
   logic [MW-1:0]           meas_s2;
   logic [MW-1:0]           meas_s3;
   logic                    done_s1;
   logic                    done_s2;
   ldr_pkg::ldr_fault_t     fault_live;
   ldr_pkg::ldr_meas_t      meas_live;
   ldr_pkg::ldr_fault_t     fault_held;
   logic [10:0]             heat_snap;
   logic [11:0]             drive_snap;
   logic [15:0]             duty_snap;
   ldr_pkg::ldr_key_state_t key_state;
   logic                    busy;
   logic [OPW-1:0]          op_count;
   logic                    shadow_hit;
   logic                    shadow_rd_q;
   logic [7:0]              shadow_q;
   logic [7:0]              next_rdata;
   logic                    wipe;
   logic                    open_key;
   logic [ldr_pkg::SHADOW_AW-1:0] shadow_addr;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   // two stages for every analog side input
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fault_s1 <= '0;
         fault_s2 <= '0;
         meas_s1  <= '0;
         meas_s2  <= '0;
         done_s1  <= 1'b0;
         done_s2  <= 1'b0;
      end else begin
         fault_s1 <= fault_in;
         fault_s2 <= fault_s1;
         meas_s1  <= meas_in;
         meas_s2  <= meas_s1;
         done_s1  <= nvm_done;
         done_s2  <= done_s1;
      end
   end

   assign fault_live = ldr_pkg::ldr_fault_t'(fault_s2);

   // new measurement word taken only after two equal samples
   // bit-wise synchronised bus, so no torn value reaches a snapshot;
   // a word that never settles keeps the last accepted value
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meas_s3   <= '0;
         meas_live <= '0;
      end else begin
         meas_s3 <= meas_s2;
         if (meas_s2 == meas_s3) begin
            meas_live <= ldr_pkg::ldr_meas_t'(meas_s2);
         end
      end
   end

   // ----------------------------------------------------------------
   // sticky fault report
   // ----------------------------------------------------------------
   // wipe strobe decode
   assign wipe = reg_wr && (reg_addr == ldr_pkg::ADDR_FAULT_WIPE)
                 && reg_wdata[ldr_pkg::WIPE_BIT];

   // flags held until wiped, new fault wins over wipe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fault_held <= ldr_pkg::ldr_fault_t'(ldr_pkg::RST_STRING_FAULT[SW-1:0]);
      end else begin
         fault_held <= (wipe ? '0 : fault_held) | fault_live;
      end
   end

   // ----------------------------------------------------------------
   // measurement snapshots
   // ----------------------------------------------------------------
   // upper temperature read captures the whole value
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         heat_snap <= '0;
      end else if (reg_rd && reg_addr == ldr_pkg::ADDR_HEAT_UPPER) begin
         heat_snap <= meas_live.die_heat;
      end
   end

   // upper drive read captures drive level and duty together
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drive_snap <= '0;
         duty_snap  <= ldr_pkg::RST_DUTY;
      end else if (reg_rd && reg_addr == ldr_pkg::ADDR_DRIVE_UPPER) begin
         drive_snap <= meas_live.string_drive_level;
         duty_snap  <= meas_live.duty;
      end
   end

   // ----------------------------------------------------------------
   // unlock sequence
   // ----------------------------------------------------------------
   assign open_key = (key_state == ldr_pkg::KEY_OPEN);

   // three key bytes in order open the store
   // any other byte returns to locked
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         key_state <= ldr_pkg::KEY_LOCKED;
      end else if (reg_wr && reg_addr == ldr_pkg::ADDR_NVM_KEY) begin
         case (key_state)
            ldr_pkg::KEY_LOCKED: begin
               key_state <= (reg_wdata == ldr_pkg::KEY_FIRST) ?
                            ldr_pkg::KEY_GOT1 : ldr_pkg::KEY_LOCKED;
            end
            ldr_pkg::KEY_GOT1: begin
               key_state <= (reg_wdata == ldr_pkg::KEY_SECOND) ?
                            ldr_pkg::KEY_GOT2 : ldr_pkg::KEY_LOCKED;
            end
            ldr_pkg::KEY_GOT2: begin
               key_state <= (reg_wdata == ldr_pkg::KEY_THIRD) ?
                            ldr_pkg::KEY_OPEN : ldr_pkg::KEY_LOCKED;
            end
            default: begin
               key_state <= ldr_pkg::KEY_LOCKED;
            end
         endcase
      end
   end

   // unlock level shown to the store macro
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nvm_unlocked <= 1'b0;
      end else begin
         nvm_unlocked <= open_key;
      end
   end

   // ----------------------------------------------------------------
   // store control and busy timing
   // ----------------------------------------------------------------
   // control bits written only while unlocked
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nvm_burn    <= ldr_pkg::RST_NVM_CONTROL[ldr_pkg::BURN_BIT];
         nvm_restore <= ldr_pkg::RST_NVM_CONTROL[ldr_pkg::RESTORE_BIT];
      end else if (reg_wr && reg_addr == ldr_pkg::ADDR_NVM_CONTROL && open_key) begin
         nvm_burn    <= reg_wdata[ldr_pkg::BURN_BIT];
         nvm_restore <= reg_wdata[ldr_pkg::RESTORE_BIT];
      end
   end

   // busy from a start until the op time ends or the macro reports done
   // a start while busy only stores the bits, the running timer goes on
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy     <= ~ldr_pkg::RST_NVM_CONTROL[ldr_pkg::IDLE_BIT];
         op_count <= '0;
      end else if (reg_wr && reg_addr == ldr_pkg::ADDR_NVM_CONTROL && open_key
                   && (reg_wdata[ldr_pkg::BURN_BIT] || reg_wdata[ldr_pkg::RESTORE_BIT])
                   && !busy) begin
         busy     <= 1'b1;
         op_count <= reg_wdata[ldr_pkg::BURN_BIT] ? OPW'(BURN_CYCLES - 1)
                                                  : OPW'(RESTORE_CYCLES - 1);
      end else if (busy) begin
         if (op_count == '0 || done_s2) begin
            busy <= 1'b0;
         end else begin
            op_count <= op_count - OPW'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // shadow register store
   // ----------------------------------------------------------------
   assign shadow_hit  = (reg_addr >= ldr_pkg::ADDR_SHADOW_FIRST)
                        && (reg_addr <= ldr_pkg::ADDR_SHADOW_LAST);
   assign shadow_addr = ldr_pkg::SHADOW_AW'(reg_addr - ldr_pkg::ADDR_SHADOW_FIRST);

   // shadows take writes only while unlocked
   ldr_shadow_mem #(
      .DEPTH (ldr_pkg::SHADOW_DEPTH),
      .AW    (ldr_pkg::SHADOW_AW)
   ) u_shadow (
      .clk   (clk),
      .we    (reg_wr && shadow_hit && open_key),
      .addr  (shadow_addr),
      .wdata (reg_wdata),
      .rdata (shadow_q)
   );

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // unlisted bits and addresses outside the shadow range read zero
   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr)
         ldr_pkg::ADDR_STRING_FAULT: begin
            next_rdata[ldr_pkg::OPEN_BIT]  = fault_held.open_string;
            next_rdata[ldr_pkg::SHORT_BIT] = fault_held.shorted_string;
            next_rdata[3:0]                = fault_held.faulty_string;
         end
         ldr_pkg::ADDR_SILICON_REV: next_rdata = {BASE_LAYER_REV, MASK_REV_STEP};
         // temperature halves, upper shows the fresh capture
         ldr_pkg::ADDR_HEAT_UPPER:  next_rdata = {5'h00, meas_live.die_heat[10:8]};
         ldr_pkg::ADDR_HEAT_LOWER:  next_rdata = heat_snap[7:0];
         ldr_pkg::ADDR_DRIVE_UPPER: next_rdata = {4'h0, meas_live.string_drive_level[11:8]};
         ldr_pkg::ADDR_DRIVE_LOWER: next_rdata = drive_snap[7:0];
         ldr_pkg::ADDR_DUTY_UPPER:  next_rdata = duty_snap[15:8];
         ldr_pkg::ADDR_DUTY_LOWER:  next_rdata = duty_snap[7:0];
         ldr_pkg::ADDR_NVM_CONTROL: begin
            next_rdata[ldr_pkg::IDLE_BIT]    = ~busy;
            next_rdata[ldr_pkg::BURN_BIT]    = nvm_burn;
            next_rdata[ldr_pkg::RESTORE_BIT] = nvm_restore;
         end
         default: next_rdata = 8'h00;
      endcase
   end

   // registered read answer, shadow data merged one cycle later
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata   <= 8'h00;
         reg_rvalid  <= 1'b0;
         shadow_rd_q <= 1'b0;
      end else begin
         shadow_rd_q <= reg_rd && shadow_hit;
         reg_rvalid  <= reg_rd && !shadow_hit || shadow_rd_q;
         if (reg_rd && !shadow_hit) begin
            reg_rdata <= next_rdata;
         end else if (shadow_rd_q) begin
            reg_rdata <= shadow_q;
         end
      end
   end
endmodule : ldr_regs

// File: bench/ldr_regs_checker.sv
/* Port assertions for the status and store register slice.
 * Bound onto ldr_regs; one clock, asynchronous active-high rst. */
module ldr_regs_checker #(
   parameter logic [3:0] BASE_LAYER_REV = 4'h1,
   parameter logic [3:0] MASK_REV_STEP  = 4'h0
) (
   input wire logic                clk,
   input wire logic                rst,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [7:0]          reg_addr,
   input wire logic [7:0]          reg_wdata,
   input wire logic [7:0]          reg_rdata,
   input wire logic                reg_rvalid,
   input wire ldr_pkg::ldr_fault_t fault_in,
   input wire ldr_pkg::ldr_meas_t  meas_in,
   input wire logic                nvm_done,
   input wire logic                nvm_burn,
   input wire logic                nvm_restore,
   input wire logic                nvm_unlocked
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic key_wr_q;

   // key write last cycle: lock state still settling
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         key_wr_q <= 1'b0;
      end else begin
         key_wr_q <= reg_wr && reg_addr == 8'h1A;
      end
   end

   AST_REV:
      assert property (reg_rd && reg_addr == 8'h12 |=> reg_rdata == {BASE_LAYER_REV, MASK_REV_STEP})
      else $error("revision readback wrong");
   AST_FAULT_RSV:
      assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata[7:6] == 2'h0)
      else $error("fault reserved bits set");
   AST_HEAT_RSV:
      assert property (reg_rd && reg_addr == 8'h13 |=> reg_rdata[7:3] == 5'h00)
      else $error("temperature upper reserved bits set");
   AST_DRIVE_RSV:
      assert property (reg_rd && reg_addr == 8'h15 |=> reg_rdata[7:4] == 4'h0)
      else $error("drive upper reserved bits set");
   AST_RVALID:
      assert property (reg_rd && reg_addr inside {[8'h10:8'h1A]} |=> reg_rvalid)
      else $error("register read not answered");
   AST_BURN:
      assert property (reg_wr && reg_addr == 8'h19 && nvm_unlocked && !key_wr_q
                       |=> nvm_burn == $past(reg_wdata[1]))
      else $error("burn level not following control write");
   AST_RESTORE:
      assert property (reg_wr && reg_addr == 8'h19 && nvm_unlocked && !key_wr_q
                       |=> nvm_restore == $past(reg_wdata[0]))
      else $error("restore level not following control write");
   AST_LOCKED:
      assert property (reg_wr && reg_addr == 8'h19 && !nvm_unlocked && !key_wr_q
                       |=> $stable(nvm_burn) && $stable(nvm_restore))
      else $error("locked control accepted a write");
   AST_RELOCK:
      assert property (reg_wr && reg_addr == 8'h1A && nvm_unlocked |-> ##2 !nvm_unlocked)
      else $error("key write while open did not relock");

   COV_BURN: cover property (nvm_burn ##1 !nvm_burn);
   COV_HEAT: cover property (reg_rd && reg_addr == 8'h13);
   COV_LOCK: cover property ($fell(nvm_unlocked));
endmodule : ldr_regs_checker

bind ldr_regs ldr_regs_checker #(
   .BASE_LAYER_REV(BASE_LAYER_REV),
   .MASK_REV_STEP(MASK_REV_STEP)
) chk_u (
   .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .fault_in(fault_in), .meas_in(meas_in), .nvm_done(nvm_done), .nvm_burn(nvm_burn),
   .nvm_restore(nvm_restore), .nvm_unlocked(nvm_unlocked)
);

// File: bench/ldr_store_model.sv
/* Behavioural nonvolatile store macro on the far side of the slice.
 * Assumes burn and restore levels from ldr_regs; fast selects an early done. */
module ldr_store_model #(
   parameter int DONE_DLY = 3
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic burn,
   input  wire logic restore,
   input  wire logic fast,
   output logic      done
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;

   // done after a delay, never when slow
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         done <= 1'b0;
      end else if (!(burn || restore)) begin
         cnt <= 0;
         done <= 1'b0;
      end else if (cnt < DONE_DLY) begin
         cnt <= cnt + 1;
      end else begin
         done <= fast;
      end
   end
endmodule : ldr_store_model

// File: bench/ldr_regs_bench.sv
/* Self-checking bench of the status and store register slice.
 * Assumes short store timers and the store model on the done input. */
module ldr_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BURN = 20;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   logic [7:0]          reg_addr = 8'h00;
   logic [7:0]          reg_wdata = 8'h00;
   logic [7:0]          reg_rdata, v, d;
   logic                reg_rvalid, nvm_done, nvm_burn, nvm_restore, nvm_unlocked;
   logic                fast = 1'b0;
   ldr_pkg::ldr_fault_t fault_in = '0;
   ldr_pkg::ldr_meas_t  meas_in = '0;
   logic [38:0]         m0;
   int                  n_fail = 0;
   int                  samples_checked = 0;
   int                  cyc = 0;

   ldr_regs #(.BURN_CYCLES(BURN), .RESTORE_CYCLES(40)) dut_u (
      .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .fault_in(fault_in), .meas_in(meas_in), .nvm_done(nvm_done), .nvm_burn(nvm_burn),
      .nvm_restore(nvm_restore), .nvm_unlocked(nvm_unlocked));
   ldr_store_model #(.DONE_DLY(3)) store_u (.clk(clk), .rst(rst), .burn(nvm_burn),
      .restore(nvm_restore), .fast(fast), .done(nvm_done));

   // 250 MHz clock
   always #2 clk = ~clk;

   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] dt);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = dt;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      int i;
      i = 0;
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      while (reg_rvalid !== 1'b1 && i < 3) begin
         @(negedge clk);
         i++;
      end
      q = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
   endtask : rd

   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      rd(a, v);
      chk(v, e);
   endtask : rc

   // key bytes, last one chosen by caller
   task automatic key(input logic [7:0] b);
      wr(8'h1A, 8'h08);
      wr(8'h1A, 8'hBA);
      wr(8'h1A, b);
      repeat (2) @(negedge clk);
   endtask : key

   // expected fault byte for a fault on string k alone
   function automatic logic [7:0] exp_fault(input int k);
      exp_fault = {2'b00, k[0], !k[0], 4'(1 << k)};
   endfunction : exp_fault

   // main sequence
   initial begin
      void'($urandom(32'h9EC1));
      repeat (12) @(negedge clk);
      rst = 1'b0;
      rc(8'h10, 8'h00);
      rc(8'h19, 8'h80);
      rc(8'h17, 8'h00);
      rc(8'h18, 8'h00);
      rc(8'h12, 8'h10);
      rc(8'h11, 8'h00);
      rc(8'h20, 8'h00);
      for (int k = 0; k < 4; k++) begin
         d = exp_fault(k);
         fault_in = d[5:0];
         repeat (4) @(negedge clk);
         wr(8'h11, 8'h01);
         rc(8'h10, d);
         fault_in = '0;
         repeat (4) @(negedge clk);
         rc(8'h10, d);
         wr(8'h11, 8'hFE);
         rc(8'h10, d);
         wr(8'h11, 8'h01);
         rc(8'h10, 8'h00);
      end
      repeat (4) begin
         m0 = 39'({$urandom(), $urandom()});
         meas_in = m0;
         repeat (4) @(negedge clk);
         rc(8'h13, {5'h00, m0[38:36]});
         meas_in = ~m0;
         repeat (4) @(negedge clk);
         rc(8'h14, m0[35:28]);
         rc(8'h15, {4'h0, ~m0[27:24]});
         meas_in = m0;
         repeat (4) @(negedge clk);
         rc(8'h16, ~m0[23:16]);
         rc(8'h17, ~m0[15:8]);
         rc(8'h18, ~m0[7:0]);
      end
      wr(8'h19, 8'h02);
      rc(8'h19, 8'h80);
      key(8'h55);
      wr(8'h19, 8'h02);
      rc(8'h19, 8'h80);
      key(8'hEF);
      chk({7'h00, nvm_unlocked}, 8'h01);
      d = 8'($urandom());
      wr(8'h60, d);
      wr(8'h78, ~d);
      rc(8'h60, d);
      rc(8'h78, ~d);
      wr(8'h19, 8'h02);
      chk({7'h00, nvm_burn}, 8'h01);
      rc(8'h19, 8'h02);
      repeat (BURN + 4) @(negedge clk);
      rc(8'h19, 8'h82);
      wr(8'h19, 8'h00);
      rc(8'h19, 8'h80);
      fast = 1'b1;
      wr(8'h19, 8'h01);
      chk({7'h00, nvm_restore}, 8'h01);
      rc(8'h19, 8'h01);
      repeat (8) @(negedge clk);
      rc(8'h19, 8'h81);
      wr(8'h19, 8'h00);
      wr(8'h1A, 8'h08);
      repeat (2) @(negedge clk);
      chk({7'h00, nvm_unlocked}, 8'h00);
      wr(8'h60, ~d);
      rc(8'h60, d);
      wr(8'h19, 8'h01);
      rc(8'h19, 8'h80);
      end_sim();
   end
endmodule : ldr_regs_bench
